// ==== rtl/ddr2_cmd_module.sv ====
/*
 * module-side command decoder, bank state, precharge, write masking,
 * power states and termination timing.
 * assumes mem_clk_in from the host is slower than ref_clk_in (oversampled);
 * all pins pass a two-flop synchroniser before use.
 */
`timescale 1ns/1ps

module ddr2_cmd_module #(
	parameter int NUM_BANKS = 8
)(
	// system
	input wire logic ref_clk_in,
	input wire logic srst_in,
	// memory clock and control pins
	input wire logic mem_clk_in,
	input wire logic clk_enable_in,
	input wire logic rank_select_n_in,
	input wire logic row_strobe_n_in,
	input wire logic col_strobe_n_in,
	input wire logic write_enable_n_in,
	input wire logic [ddr2_cmd_pkg::BANK_W-1:0] bank_in,
	input wire logic [ddr2_cmd_pkg::ADDR_W-1:0] addr_in,
	input wire logic termination_ctl_in,
	// write data path
	input wire logic [ddr2_cmd_pkg::DQ_W-1:0] wdata_in,
	input wire logic [ddr2_cmd_pkg::MASK_W-1:0] data_mask_in,
	input wire logic write_strobe_in,
	// status and decoded outputs
	output logic [NUM_BANKS-1:0] bank_open_out,
	output logic [ddr2_cmd_pkg::ADDR_W-1:0] row_addr_out,
	output logic [ddr2_cmd_pkg::COL_W-1:0] col_addr_out,
	output logic [ddr2_cmd_pkg::BANK_W-1:0] cmd_bank_out,
	output logic [2:0] cmd_out,
	output logic cmd_valid_out,
	output logic read_beat_out,
	output logic [ddr2_cmd_pkg::DQ_W-1:0] wdata_out,
	output logic [ddr2_cmd_pkg::MASK_W-1:0] byte_write_out,
	output logic write_beat_out,
	output logic termination_on_out,
	output logic [1:0] power_state_out
);
	// a bank vector that does not match the bank address cannot be decoded
	if (NUM_BANKS != (1 << ddr2_cmd_pkg::BANK_W))
	begin : g_bank_check
		$error("NUM_BANKS must match the bank address width");
	end

	// ==========================================================
	// pin synchronisers
	// ==========================================================
	localparam int SYNC_W = 7 + ddr2_cmd_pkg::BANK_W + ddr2_cmd_pkg::ADDR_W;
	logic [SYNC_W-1:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
	logic [ddr2_cmd_pkg::DQ_W+ddr2_cmd_pkg::MASK_W-1:0] dsync1_reg, dsync2_reg;
	logic mclk_prev_reg, mclk_prev_next;

	// first stage is read only by the second stage
	always_comb
	begin
		sync1_next = {mem_clk_in, clk_enable_in, rank_select_n_in, row_strobe_n_in,
			col_strobe_n_in, write_enable_n_in, termination_ctl_in, bank_in, addr_in};
		sync2_next = sync1_reg;
		mclk_prev_next = sync2_reg[SYNC_W-1];
	end

	always_ff @(posedge ref_clk_in)
	begin
		sync1_reg <= sync1_next;
		sync2_reg <= sync2_next;
		dsync1_reg <= {wdata_in, data_mask_in};
		dsync2_reg <= dsync1_reg;
		mclk_prev_reg <= mclk_prev_next;
	end

	// unpack the synchronised pins
	logic mclk_s, cke_s, rank_n_s, term_s;
	logic [2:0] strobes_s;
	logic [ddr2_cmd_pkg::BANK_W-1:0] bank_s;
	logic [ddr2_cmd_pkg::ADDR_W-1:0] addr_s;
	assign {mclk_s, cke_s, rank_n_s, strobes_s, term_s, bank_s, addr_s} = sync2_reg;

	// the strobe rides with the data flops so all beat fields stay aligned
	logic wstb1_reg, wstb2_reg, wstb_prev_reg;
	always_ff @(posedge ref_clk_in)
	begin
		wstb1_reg <= write_strobe_in;
		wstb2_reg <= wstb1_reg;
		wstb_prev_reg <= wstb2_reg;
	end

	logic rise, fall;
	assign rise = mclk_s && !mclk_prev_reg;
	assign fall = !mclk_s && mclk_prev_reg;

	// ==========================================================
	// command decode and bank state
	// ==========================================================
	ddr2_cmd_pkg::power_type power_reg, power_next;
	logic [NUM_BANKS-1:0] open_reg, open_next;
	logic [ddr2_cmd_pkg::ADDR_W-1:0] row_reg, row_next;
	logic [ddr2_cmd_pkg::COL_W-1:0] col_reg, col_next;
	logic [ddr2_cmd_pkg::BANK_W-1:0] cbank_reg, cbank_next;
	logic [2:0] cmd_reg, cmd_next;
	logic cvalid_reg, cvalid_next;
	logic [1:0] term_mode_reg, term_mode_next;
	logic [3:0] burst_reg, burst_next;
	logic burst_rd_reg, burst_rd_next, auto_pre_reg, auto_pre_next;
	logic [ddr2_cmd_pkg::BANK_W-1:0] burst_bank_reg, burst_bank_next;
	logic rbeat_reg, rbeat_next;
	logic [2:0] cmd;

	// a deselected rank decodes as no-operation, so nothing new starts
	assign cmd = rank_n_s ? ddr2_cmd_pkg::CMD_NOP : strobes_s;

	function automatic logic [NUM_BANKS-1:0] bank_onehot(
		input logic [ddr2_cmd_pkg::BANK_W-1:0] b);
		bank_onehot = NUM_BANKS'(1) << b;
	endfunction : bank_onehot

	always_comb
	begin
		power_next = power_reg;
		open_next = open_reg;
		row_next = row_reg;
		col_next = col_reg;
		cbank_next = cbank_reg;
		cmd_next = cmd_reg;
		cvalid_next = 1'b0;
		term_mode_next = term_mode_reg;
		burst_next = burst_reg;
		burst_rd_next = burst_rd_reg;
		auto_pre_next = auto_pre_reg;
		burst_bank_next = burst_bank_reg;
		rbeat_next = 1'b0;
		// burst in flight counts down on both clock edges regardless of rank select
		if ((rise || fall) && burst_reg != 4'h0)
		begin
			burst_next = burst_reg - 4'h1;
			rbeat_next = burst_rd_reg;
			if (burst_reg == 4'h1 && auto_pre_reg)
				open_next[burst_bank_reg] = 1'b0;
		end
		if (rise)
		begin
			case (power_reg)
				ddr2_cmd_pkg::ST_ACTIVE:
				begin
					if (!cke_s)
						// clock stops: refresh command context picks self-refresh
						power_next = (cmd == ddr2_cmd_pkg::CMD_REFRESH) ?
							ddr2_cmd_pkg::ST_SELFREFRESH : ddr2_cmd_pkg::ST_POWERDOWN;
					else if (cmd != ddr2_cmd_pkg::CMD_NOP)
					begin
						cvalid_next = 1'b1;
						cmd_next = cmd;
						cbank_next = bank_s;
						case (cmd)
							ddr2_cmd_pkg::CMD_ACTIVATE:
							begin
								row_next = addr_s;
								// a burst closing this bank in the same cycle loses to the activate
								open_next = open_next | bank_onehot(bank_s);
							end
							ddr2_cmd_pkg::CMD_READ, ddr2_cmd_pkg::CMD_WRITE:
							begin
								col_next = addr_s[ddr2_cmd_pkg::COL_W-1:0];
								burst_next = 4'(ddr2_cmd_pkg::BURST_BEATS);
								burst_rd_next = (cmd == ddr2_cmd_pkg::CMD_READ);
								auto_pre_next = addr_s[ddr2_cmd_pkg::PRECHARGE_BIT];
								burst_bank_next = bank_s;
							end
							ddr2_cmd_pkg::CMD_PRECHARGE:
							begin
								if (addr_s[ddr2_cmd_pkg::PRECHARGE_BIT])
									open_next = '0;
								else
									open_next = open_next & ~bank_onehot(bank_s);
							end
							ddr2_cmd_pkg::CMD_MODE:
							begin
								if (bank_s == ddr2_cmd_pkg::EXT_MODE_BANK)
									term_mode_next = {addr_s[ddr2_cmd_pkg::TERM_EN_BIT1],
										addr_s[ddr2_cmd_pkg::TERM_EN_BIT0]};
							end
							default:
							begin
								cvalid_next = 1'b1;
							end
						endcase
					end
				end
				default:
				begin
					if (cke_s)
						power_next = ddr2_cmd_pkg::ST_ACTIVE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			power_reg <= ddr2_cmd_pkg::ST_ACTIVE;
			open_reg <= '0;
			row_reg <= '0;
			col_reg <= '0;
			cbank_reg <= '0;
			cmd_reg <= ddr2_cmd_pkg::CMD_NOP;
			cvalid_reg <= 1'b0;
			term_mode_reg <= 2'h0;
			burst_reg <= 4'h0;
			burst_rd_reg <= 1'b0;
			auto_pre_reg <= 1'b0;
			burst_bank_reg <= '0;
			rbeat_reg <= 1'b0;
		end
		else
		begin
			power_reg <= power_next;
			open_reg <= open_next;
			row_reg <= row_next;
			col_reg <= col_next;
			cbank_reg <= cbank_next;
			cmd_reg <= cmd_next;
			cvalid_reg <= cvalid_next;
			term_mode_reg <= term_mode_next;
			burst_reg <= burst_next;
			burst_rd_reg <= burst_rd_next;
			auto_pre_reg <= auto_pre_next;
			burst_bank_reg <= burst_bank_next;
			rbeat_reg <= rbeat_next;
		end
	end

	// ==========================================================
	// write masking
	// ==========================================================
	logic [ddr2_cmd_pkg::DQ_W-1:0] wdata_reg, wdata_next;
	logic [ddr2_cmd_pkg::MASK_W-1:0] bwe_reg, bwe_next;
	logic wbeat_reg, wbeat_next;
	logic [ddr2_cmd_pkg::DQ_W-1:0] wdata_s;
	logic [ddr2_cmd_pkg::MASK_W-1:0] mask_s;
	assign wdata_s = dsync2_reg[ddr2_cmd_pkg::DQ_W+ddr2_cmd_pkg::MASK_W-1:ddr2_cmd_pkg::MASK_W];
	assign mask_s = dsync2_reg[ddr2_cmd_pkg::MASK_W-1:0];

	// beats are taken on both strobe edges; a masked byte never reaches the array
	always_comb
	begin
		wdata_next = wdata_reg;
		bwe_next = bwe_reg;
		wbeat_next = 1'b0;
		if (wstb2_reg != wstb_prev_reg && burst_reg != 4'h0 && !burst_rd_reg)
		begin
			wbeat_next = 1'b1;
			wdata_next = wdata_s;
			bwe_next = ~mask_s;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			wdata_reg <= '0;
			bwe_reg <= '0;
			wbeat_reg <= 1'b0;
		end
		else
		begin
			wdata_reg <= wdata_next;
			bwe_reg <= bwe_next;
			wbeat_reg <= wbeat_next;
		end
	end

	// ==========================================================
	// termination timing, counted in memory clock half-cycles
	// ==========================================================
	logic term_reg, term_next;
	logic [2:0] tcnt_reg, tcnt_next;
	logic tgt_reg, tgt_next;
	logic term_allowed;
	assign term_allowed = term_mode_reg != 2'h0;

	always_comb
	begin
		term_next = term_reg;
		tcnt_next = tcnt_reg;
		tgt_next = tgt_reg;
		if (power_reg != ddr2_cmd_pkg::ST_ACTIVE || !term_allowed)
		begin
			// the fixed delay only holds in the active state, not in power-down or self-refresh
			term_next = term_s && term_allowed;
			tgt_next = term_next;
			tcnt_next = 3'h0;
		end
		else
		begin
			if (rise && term_s != tgt_reg)
			begin
				tgt_next = term_s;
				tcnt_next = term_s ? 3'(ddr2_cmd_pkg::TERM_ON_HALVES) :
					3'(ddr2_cmd_pkg::TERM_OFF_HALVES);
			end
			else if ((rise || fall) && tcnt_reg != 3'h0)
			begin
				tcnt_next = tcnt_reg - 3'h1;
				if (tcnt_reg == 3'h1)
					term_next = tgt_reg;
			end
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			term_reg <= 1'b0;
			tcnt_reg <= 3'h0;
			tgt_reg <= 1'b0;
		end
		else
		begin
			term_reg <= term_next;
			tcnt_reg <= tcnt_next;
			tgt_reg <= tgt_next;
		end
	end

	// ==========================================================
	// outputs
	// ==========================================================
	assign bank_open_out = open_reg;
	assign row_addr_out = row_reg;
	assign col_addr_out = col_reg;
	assign cmd_bank_out = cbank_reg;
	assign cmd_out = cmd_reg;
	assign cmd_valid_out = cvalid_reg;
	assign read_beat_out = rbeat_reg;
	assign wdata_out = wdata_reg;
	assign byte_write_out = bwe_reg;
	assign write_beat_out = wbeat_reg;
	assign termination_on_out = term_reg;
	assign power_state_out = power_reg;

	// ==========================================================
	// checks
	// ==========================================================
	a_rank_ignore: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(rise && rank_n_s) |=> !cvalid_reg)
		else $error("deselected rank decoded a command");
	a_precharge_all: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(rise && cke_s && power_reg == ddr2_cmd_pkg::ST_ACTIVE && cmd == ddr2_cmd_pkg::CMD_PRECHARGE
		&& addr_s[ddr2_cmd_pkg::PRECHARGE_BIT] && burst_reg == 4'h0) |=> open_reg == '0)
		else $error("precharge all left a bank open");
	a_mask_drop: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		wbeat_reg |-> byte_write_out == ~$past(mask_s))
		else $error("masked byte written");
	a_term_gate: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		!term_allowed |=> !term_reg)
		else $error("termination on while disabled");
	a_cke_entry: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(rise && !cke_s && power_reg == ddr2_cmd_pkg::ST_ACTIVE)
		|=> power_reg != ddr2_cmd_pkg::ST_ACTIVE)
		else $error("clock enable low left the rank active");
	a_row_capture: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		(rise && cke_s && power_reg == ddr2_cmd_pkg::ST_ACTIVE
		&& cmd == ddr2_cmd_pkg::CMD_ACTIVATE)
		|=> row_reg == $past(addr_s) && open_reg[$past(bank_s)])
		else $error("activate lost its row or bank");
endmodule : ddr2_cmd_module

// ==== rtl/ddr2_cmd_pkg.sv ====
/*
 * constants for the module-side command decoder and termination timing.
 * assumes a single 50 MHz system clock that oversamples the memory clock pin.
 */
package ddr2_cmd_pkg;
	localparam int ADDR_W = 14;
	localparam int BANK_W = 3;
	localparam int MASK_W = 8;
	localparam int DQ_W = 64;
	localparam int PRECHARGE_BIT = 10;
	localparam int COL_W = 10;
	// extended mode set: bank code and termination enable field
	localparam logic [2:0] EXT_MODE_BANK = 3'h1;
	localparam int TERM_EN_BIT0 = 2;
	localparam int TERM_EN_BIT1 = 6;
	// termination timing in memory clock half-cycles
	localparam int TERM_ON_HALVES = 4;
	localparam int TERM_OFF_HALVES = 5;
	localparam int BURST_BEATS = 8;
	// command codes {ras_n, cas_n, we_n}
	localparam logic [2:0] CMD_MODE = 3'h0;
	localparam logic [2:0] CMD_REFRESH = 3'h1;
	localparam logic [2:0] CMD_PRECHARGE = 3'h2;
	localparam logic [2:0] CMD_ACTIVATE = 3'h3;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_NOP = 3'h7;
	typedef enum logic [1:0] {ST_ACTIVE, ST_POWERDOWN, ST_SELFREFRESH} power_type;
endpackage : ddr2_cmd_pkg

// ==== test/ddr2_host_model.sv ====
/*
 * host controller model: memory clock, clock enable, rank select,
 * command strobes, bank, address and termination control.
 * assumes the bench calls its tasks; the memory clock only runs inside them.
 */
`timescale 1ns/1ps
module ddr2_host_model (
	// system
	input wire logic ref_clk_in,
	// pins towards the module
	output logic mem_clk_out,
	output logic cke_out,
	output logic rank_n_out,
	output logic [2:0] cmd_out,
	output logic [ddr2_cmd_pkg::BANK_W-1:0] bank_out,
	output logic [ddr2_cmd_pkg::ADDR_W-1:0] addr_out,
	output logic term_out
);
	// ==========================================================
	// idle pins at time zero
	initial
	begin
		mem_clk_out = 1'b0;
		cke_out = 1'b1;
		rank_n_out = 1'b1;
		cmd_out = ddr2_cmd_pkg::CMD_NOP;
		bank_out = 3'h0;
		addr_out = 14'h0000;
		term_out = 1'b0;
	end

	// the high half of the memory clock is four system clocks; send adds one to the low half, for 180 ns
	task half();
		repeat (4) @(negedge ref_clk_in);
	endtask : half

	// one command cycle; pins change at the low phase, the module samples at the rise
	task send(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a,
		input logic r_n);
		@(negedge ref_clk_in);
		cmd_out = c;
		bank_out = b;
		addr_out = a;
		rank_n_out = r_n;
		half();
		mem_clk_out = 1'b1;
		half();
		mem_clk_out = 1'b0;
		// released bank and address lines show the inverse so a stale value is never trusted
		cmd_out = ddr2_cmd_pkg::CMD_NOP;
		bank_out = ~b;
		addr_out = ~a;
		rank_n_out = 1'b1;
	endtask : send

	// deselected cycles keep every spacing limit, rounded up to whole clocks;
	// the scenarios put enough of them between commands
	task idle(input int n);
		for (int k = 0; k < n; k++)
			send(ddr2_cmd_pkg::CMD_NOP, bank_out, addr_out, 1'b1);
	endtask : idle

	// callers hold each clock enable level for at least three command cycles
	task set_cke(input logic v);
		cke_out = v;
	endtask : set_cke

	// termination is settled long before any power-down entry
	task set_term(input logic v);
		term_out = v;
	endtask : set_term
endmodule : ddr2_host_model

// ==== test/ddr2_module_command_timing_test.sv ====
/*
 * self-checking bench: host model drives the command pins, the bench drives write data, mask and strobe; one task per scenario.
 * assumes a 50 MHz system clock and a 180 ns memory clock from the model.
 */
`timescale 1ns/1ps
module ddr2_module_command_timing_test;
	logic clk;
	logic srst;
	logic wstb;
	logic [63:0] wdat;
	logic [7:0] mask;
	logic mclk, cke, rank_n, term;
	logic [2:0] hcmd, hbank, cmd, cbank;
	logic [13:0] haddr, row;
	logic [9:0] col;
	logic [7:0] open, bw, lbw;
	logic [63:0] wout, lwd;
	logic cvalid, rbeat, wbeat, t_on;
	logic [1:0] pstate;
	logic [2:0] lcmd;
	logic ras_n, cas_n, we_n;
	logic mprev = 1'b0;
	logic tprev = 1'b0;
	int bad_count, n_checks, ncmd, nbeat, cyc;
	int nwbeat, medges, ton_edge, toff_edge;

	// command strobes split out of the host's packed code
	assign {ras_n, cas_n, we_n} = hcmd;

	ddr2_host_model host (.ref_clk_in(clk), .mem_clk_out(mclk), .cke_out(cke),
		.rank_n_out(rank_n), .cmd_out(hcmd), .bank_out(hbank), .addr_out(haddr),
		.term_out(term));

	ddr2_cmd_module DUT (.ref_clk_in(clk), .srst_in(srst), .mem_clk_in(mclk),
		.clk_enable_in(cke), .rank_select_n_in(rank_n), .row_strobe_n_in(ras_n),
		.col_strobe_n_in(cas_n), .write_enable_n_in(we_n), .bank_in(hbank),
		.addr_in(haddr), .termination_ctl_in(term), .wdata_in(wdat),
		.data_mask_in(mask), .write_strobe_in(wstb), .bank_open_out(open),
		.row_addr_out(row), .col_addr_out(col), .cmd_bank_out(cbank), .cmd_out(cmd),
		.cmd_valid_out(cvalid), .read_beat_out(rbeat), .wdata_out(wout),
		.byte_write_out(bw), .write_beat_out(wbeat), .termination_on_out(t_on),
		.power_state_out(pstate));

	// ==========================================================
	// clock, pulse counters and hang guard
	initial clk = 1'b0;
	always #10 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (cvalid === 1'b1)
		begin
			ncmd++;
			lcmd = cmd;
		end
		if (rbeat === 1'b1)
			nbeat++;
		if (wbeat === 1'b1)
		begin
			lbw = bw;
			lwd = wout;
			nwbeat++;
		end
		// memory clock edges are counted half a system clock after the pin moves, at the next rise
		if (mclk !== mprev)
			medges++;
		mprev = mclk;
		if (t_on === 1'b1 && tprev !== 1'b1)
			ton_edge = medges;
		if (t_on === 1'b0 && tprev === 1'b1)
			toff_edge = medges;
		tprev = t_on;
		if (cyc == 8000)
		begin
			bad_count++;
			results();
		end
	end

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// ==========================================================
	// scenarios
	task t_activate();
		ncmd = 0;
		host.send(ddr2_cmd_pkg::CMD_ACTIVATE, 3'h2, 14'h3FFF, 1'b0);
		host.idle(1);
		chk("cmd count", 16'h1, ncmd[15:0]);
		chk("cmd code", {13'h0, ddr2_cmd_pkg::CMD_ACTIVATE}, {13'h0, lcmd});
		chk("row", 16'h3FFF, {2'h0, row});
		chk("bank", 16'h2, {13'h0, cbank});
		chk("open", 16'h0004, {8'h0, open});
		// deselected activate must be ignored
		host.send(ddr2_cmd_pkg::CMD_ACTIVATE, 3'h5, 14'h0000, 1'b1);
		host.idle(1);
		chk("ignored cmd", 16'h1, ncmd[15:0]);
		chk("open", 16'h0004, {8'h0, open});
	endtask : t_activate

	task t_read();
		nbeat = 0;
		host.send(ddr2_cmd_pkg::CMD_ACTIVATE, 3'h3, 14'h0001, 1'b0);
		host.idle(2);
		host.send(ddr2_cmd_pkg::CMD_READ, 3'h3, 14'h0155, 1'b0);
		// a deselected command mid-burst must not cut the burst short
		host.send(ddr2_cmd_pkg::CMD_ACTIVATE, 3'h6, 14'h0000, 1'b1);
		host.idle(6);
		chk("col", 16'h0155, {6'h0, col});
		chk("beats", 16'h8, nbeat[15:0]);
		chk("open", 16'h000C, {8'h0, open});
		host.send(ddr2_cmd_pkg::CMD_READ, 3'h2, 14'h0400, 1'b0);
		host.idle(8);
		chk("beats", 16'h10, nbeat[15:0]);
		chk("open", 16'h0008, {8'h0, open});
	endtask : t_read

	task t_write();
		nwbeat = 0;
		host.send(ddr2_cmd_pkg::CMD_WRITE, 3'h3, 14'h0010, 1'b0);
		for (int i = 0; i < ddr2_cmd_pkg::BURST_BEATS; i++)
		begin
			@(negedge clk);
			mask = 8'h01 << i;
			wdat = {8{8'h11 * i[7:0]}};
			wstb = ~wstb;
			repeat (8) @(negedge clk);
			chk("byte write", {8'h0, ~mask}, {8'h0, lbw});
			chk("data low", wdat[15:0], lwd[15:0]);
			chk("data high", wdat[63:48], lwd[63:48]);
		end
		chk("write beats", 16'h8, nwbeat[15:0]);
	endtask : t_write

	task t_precharge();
		host.send(ddr2_cmd_pkg::CMD_ACTIVATE, 3'h1, 14'h0002, 1'b0);
		host.idle(2);
		host.send(ddr2_cmd_pkg::CMD_PRECHARGE, 3'h1, 14'h0000, 1'b0);
		host.idle(1);
		chk("open", 16'h0008, {8'h0, open});
		host.send(ddr2_cmd_pkg::CMD_PRECHARGE, 3'h0, 14'h0400, 1'b0);
		host.idle(1);
		chk("open", 16'h0000, {8'h0, open});
	endtask : t_precharge

	task t_term();
		int e0;
		host.send(ddr2_cmd_pkg::CMD_MODE, ddr2_cmd_pkg::EXT_MODE_BANK, 14'h0004, 1'b0);
		host.idle(2);
		// let the last clock fall be counted before taking the edge mark;
		// the control is sampled at edge e0+1, on 4 half-cycles later, off 5
		@(negedge clk);
		e0 = medges;
		host.set_term(1'b1);
		host.idle(1);
		chk("term early", 16'h0, {15'h0, t_on});
		host.idle(2);
		chk("term on", 16'h1, {15'h0, t_on});
		chk("term on edge", 16'(e0 + 5), ton_edge[15:0]);
		@(negedge clk);
		e0 = medges;
		host.set_term(1'b0);
		host.idle(2);
		chk("term hold", 16'h1, {15'h0, t_on});
		host.idle(2);
		chk("term off", 16'h0, {15'h0, t_on});
		chk("term off edge", 16'(e0 + 6), toff_edge[15:0]);
		// termination disabled in the extended mode must keep it off
		host.send(ddr2_cmd_pkg::CMD_MODE, ddr2_cmd_pkg::EXT_MODE_BANK, 14'h0000, 1'b0);
		host.idle(2);
		host.set_term(1'b1);
		host.idle(4);
		chk("term disabled", 16'h0, {15'h0, t_on});
		host.set_term(1'b0);
		host.idle(4);
	endtask : t_term

	task t_power();
		host.set_cke(1'b0);
		host.idle(3);
		chk("power down", 16'h1, {14'h0, pstate});
		host.set_cke(1'b1);
		host.idle(3);
		chk("active", 16'h0, {14'h0, pstate});
		host.set_cke(1'b0);
		// array contents are not modelled, so this is the only refresh the run needs
		host.send(ddr2_cmd_pkg::CMD_REFRESH, 3'h0, 14'h0000, 1'b0);
		host.idle(2);
		chk("self refresh", 16'h2, {14'h0, pstate});
		host.set_cke(1'b1);
		host.idle(3);
		chk("active", 16'h0, {14'h0, pstate});
	endtask : t_power

	task t_reset();
		host.send(ddr2_cmd_pkg::CMD_ACTIVATE, 3'h4, 14'h0123, 1'b0);
		host.idle(1);
		chk("open", 16'h0010, {8'h0, open});
		// a reset in mid-run closes every bank and restores the idle command code
		@(negedge clk);
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		chk("reset open", 16'h0, {8'h0, open});
		chk("reset cmd", {13'h0, ddr2_cmd_pkg::CMD_NOP}, {13'h0, cmd});
		chk("reset power", 16'h0, {14'h0, pstate});
		host.send(ddr2_cmd_pkg::CMD_ACTIVATE, 3'h4, 14'h0123, 1'b0);
		host.idle(1);
		chk("open again", 16'h0010, {8'h0, open});
		chk("row again", 16'h0123, {2'h0, row});
	endtask : t_reset

	task results();
		if (bad_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	// ==========================================================
	// main sequence
	initial
	begin
		srst = 1'b1;
		wstb = 1'b0;
		wdat = 64'h0;
		mask = 8'h00;
		lbw = 8'h00;
		repeat (12) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		t_activate();
		t_read();
		t_write();
		t_precharge();
		t_term();
		t_power();
		t_reset();
		results();
	end
endmodule : ddr2_module_command_timing_test
